// *** capwd_chk.sv ***
// ****************************************
// Port checker for the output modes and watchdog
// ****************************************
module capwd_chk
  import capwd_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Register port
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  input  wire logic [7:0] reg_rdata,
  // Outputs
  input  wire logic [5:0] module_io_pin,
  input  wire logic       irq,
  input  wire logic       watchdog_reset
);
  logic       wdog;
  logic       lock;
  logic       run_sw;
  logic [7:0] mode0;
  wire  logic wd_on   = wdog | lock;
  wire  logic wr_ctl  = reg_write && reg_addr == ADDR_CONTROL;
  wire  logic pwm_off = mode0[MM_PWM] && !mode0[MM_CMP] && !mode0[MM_TOG];
  // Shadow bits; the lock only falls at reset, so it is never copied from data
  always_ff @(posedge clock) begin
    if (reset) begin
      wdog   <= 1'b1;
      lock   <= 1'b0;
      run_sw <= 1'b0;
      mode0  <= 8'h00;
    end else if (reg_write) begin
      if (reg_addr == ADDR_MODE) wdog <= reg_wdata[MD_WDOG];
      if (reg_addr == ADDR_MODE) lock <= lock | reg_wdata[MD_LOCK];
      if (wr_ctl) run_sw <= reg_wdata[CTL_RUN];
      if (reg_addr == 5'h08) mode0 <= reg_wdata;
      if (reg_addr == 5'h09) mode0[MM_CMP] <= 1'b0;
      if (reg_addr == 5'h0A) mode0[MM_CMP] <= 1'b1;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == 8'h00)
    else $error("read data seen without a read");
  wdreset_pulse_a: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog reset longer than one cycle");
  force_reset_a: assert property (wr_ctl && reg_wdata[5] && wd_on |-> ##[1:2] watchdog_reset)
    else $error("flag write did not force a reset");
  wd_quiet_a: assert property (!wd_on && !$past(wd_on) |-> !watchdog_reset)
    else $error("reset while watchdog disabled");
  run_read_a: assert property (reg_read && reg_addr == ADDR_CONTROL && !run_sw |=>
    !reg_rdata[CTL_RUN])
    else $error("run bit reads one unless written");
  mode_read_a: assert property (reg_read && reg_addr == ADDR_MODE |=>
    (reg_rdata[MD_WDOG] | reg_rdata[MD_LOCK]) == $past(wd_on))
    else $error("watchdog enable state wrong");
  pwm_zero_a: assert property (pwm_off && $past(pwm_off) |-> !module_io_pin[0])
    else $error("disabled PWM drives pin high");
  unmapped_read_a: assert property (reg_read && reg_addr == 5'h1F |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  pins_reset_a: assert property ($fell(reset) |-> module_io_pin == 6'h3F)
    else $error("pins not high after reset");
  cover property (watchdog_reset);
  cover property (module_io_pin[0] ##1 !module_io_pin[0]);
  cover property (pwm_off && $past(pwm_off));
endmodule : capwd_chk

bind capwd_top capwd_chk chk (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read,
  .reg_rdata, .module_io_pin, .irq, .watchdog_reset);

// *** capwd_load.sv ***
// External load on one module pin: counts toggles and high cycles
module capwd_load (
  // Clock and pin
  input  wire logic        clock,
  input  wire logic        pin,
  // Measurement
  input  wire logic        clear,
  output logic      [15:0] edges,
  output logic      [15:0] highs
);
  timeunit 1ns;
  timeprecision 100ps;
  logic last;
  // Clear zeroes both counts so each window starts clean
  always_ff @(posedge clock) begin
    last <= pin;
    if (clear) begin
      edges <= 16'h0000;
      highs <= 16'h0000;
    end else begin
      edges <= edges + 16'(pin != last);
      highs <= highs + 16'(pin);
    end
  end
endmodule : capwd_load

// *** capwd_pkg.sv ***
// Overview of operation
// - Frequency mode: low match toggles, adds high
// - High byte zero means 256 clock half-period
// - Frequency mode needs enable, toggle, pwm bits
// - 8-bit PWM: low match drives output high
// - 8-bit PWM: low byte overflow drives low
// - 8-bit PWM: low byte wrap reloads from high
// - 8-bit PWM: enable, pwm set, toggle and wide clear
// - Low write clears enable, high write sets
// - Enable clear gives zero duty in PWM
// - 16-bit PWM: word match high, overflow low
// - 16-bit PWM: enable, pwm, wide all set, toggle clear
// - Watchdog compares module 5 high byte
// - Reset enables watchdog, div12, clears bytes
// - Watchdog freezes counter writes and module 5 mode
// - Watchdog forces counting; run bit reads software value
// - Watchdog byte write loads high plus offset
// - Low overflow with high match resets chip
// - Writing one to flag 5 forces reset
// - Enable or lock enables; lock holds until reset
// - Three-bit timebase select of counter clock
// - Event flags set by hardware, cleared by software
// - Idle-halt bit suspends counter during idle
package capwd_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [4:0] ADDR_CONTROL  = 5'h00;
  localparam logic [4:0] ADDR_MODE     = 5'h01;
  localparam logic [4:0] ADDR_CNT_LOW  = 5'h02;
  localparam logic [4:0] ADDR_CNT_HIGH = 5'h03;
  localparam logic [4:0] ADDR_MOD_BASE = 5'h08;
  localparam int         MODULES       = 6;
  localparam int         WDOG_MODULE   = 5;
  // Control: bit 6 run, bits 5..0 event flags
  localparam int         CTL_RUN       = 6;
  // Mode register fields
  localparam int         MD_IDLE       = 7;
  localparam int         MD_LOCK       = 6;
  localparam int         MD_WDOG       = 5;
  localparam int         MD_TB_LSB     = 1;
  localparam logic [7:0] MODE_RESET    = 8'h20;
  // Module mode fields
  localparam int         MM_WIDE       = 7;
  localparam int         MM_CMP        = 6;
  localparam int         MM_MAT        = 3;
  localparam int         MM_TOG        = 2;
  localparam int         MM_PWM        = 1;
  localparam int         MM_IRQ        = 0;
  localparam logic [7:0] MM_SWTIMER    = 8'h48;
  // Timebase codes
  typedef enum logic [2:0] {
    CAPWD_TB_DIV12 = 3'b000, CAPWD_TB_DIV4 = 3'b001, CAPWD_TB_T0 = 3'b010,
    CAPWD_TB_EXT = 3'b011, CAPWD_TB_SYS = 3'b100, CAPWD_TB_XOSC = 3'b101,
    CAPWD_TB_RTC = 3'b110, CAPWD_TB_NONE = 3'b111
  } capwd_tb_t;
  localparam logic [3:0] DIV12_LAST    = 4'hB;
  localparam logic [3:0] DIV4_LAST     = 4'h3;
  localparam logic [2:0] DIV8_LAST     = 3'h7;
endpackage : capwd_pkg

// *** capwd_sync.sv ***
// Three-stage synchroniser; change accepted when stages two and three agree
module capwd_sync (
  // Clock and reset
  input  wire logic clock,
  input  wire logic reset,
  // Signals
  input  wire logic async_in,
  output logic      sync_out
);
  import capwd_pkg::*;
  logic s1;
  logic s2;
  logic s3;
  // ****************************************
  // Stages
  // ****************************************
  always_ff @(posedge clock) begin
    if (reset) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) sync_out <= s3;
    end
  end
endmodule : capwd_sync

// *** capwd_timebase.sv ***
// Counter clock enable selection
module capwd_timebase (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Selection
  input  wire logic [2:0] select,
  // Sources
  input  wire logic       timer0_tick,
  input  wire logic       ext_in,
  input  wire logic       xosc_in,
  input  wire logic       rtc_in,
  // Tick
  output logic            tick
);
  import capwd_pkg::*;
  logic [3:0] div12;
  logic [3:0] div4;
  logic [2:0] xcnt;
  logic [2:0] rcnt;
  logic       ext_s;
  logic       xosc_s;
  logic       rtc_s;
  logic       ext_d;
  logic       xosc_d;
  logic       rtc_d;
  capwd_sync u_ext  (.clock(clock), .reset(reset), .async_in(ext_in),  .sync_out(ext_s));
  capwd_sync u_xosc (.clock(clock), .reset(reset), .async_in(xosc_in), .sync_out(xosc_s));
  capwd_sync u_rtc  (.clock(clock), .reset(reset), .async_in(rtc_in),  .sync_out(rtc_s));
  wire ext_fall  = ext_d & ~ext_s;
  wire xosc_rise = xosc_s & ~xosc_d;
  wire rtc_rise  = rtc_s & ~rtc_d;
  wire d12_tick  = (div12 == DIV12_LAST);
  wire d4_tick   = (div4 == DIV4_LAST);
  wire x8_tick   = xosc_rise & (xcnt == DIV8_LAST);
  wire r8_tick   = rtc_rise & (rcnt == DIV8_LAST);
  // Dividers and edge history
  always_ff @(posedge clock) begin
    if (reset) begin
      div12 <= 4'h0;
      div4 <= 4'h0;
      xcnt <= 3'h0;
      rcnt <= 3'h0;
      ext_d <= 1'b0;
      xosc_d <= 1'b0;
      rtc_d <= 1'b0;
    end else begin
      div12 <= d12_tick ? 4'h0 : div12 + 4'h1;
      div4 <= d4_tick ? 4'h0 : div4 + 4'h1;
      if (xosc_rise) xcnt <= xcnt + 3'h1;
      if (rtc_rise) rcnt <= rcnt + 3'h1;
      ext_d <= ext_s;
      xosc_d <= xosc_s;
      rtc_d <= rtc_s;
    end
  end
  // Source mux; edge sources limited by synchroniser to sys/4 anyway
  always_comb begin
    case (capwd_tb_t'(select))
      CAPWD_TB_DIV12: tick = d12_tick;
      CAPWD_TB_DIV4:  tick = d4_tick;
      CAPWD_TB_T0:    tick = timer0_tick;
      CAPWD_TB_EXT:   tick = ext_fall;
      CAPWD_TB_SYS:   tick = 1'b1;
      CAPWD_TB_XOSC:  tick = x8_tick;
      CAPWD_TB_RTC:   tick = r8_tick;
      default:        tick = 1'b0;
    endcase
  end
endmodule : capwd_timebase

// *** capwd_top.sv ***
// Counter array output modes and watchdog
module capwd_top (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       reset,
  // Register port
  input  wire logic [4:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_write,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  // Timebase sources and CPU state
  input  wire logic       timer0_tick,
  input  wire logic       ext_clock_in,
  input  wire logic       xosc_in,
  input  wire logic       rtc_in,
  input  wire logic       cpu_idle,
  // Outputs
  output logic      [5:0] module_io_pin,
  output logic            irq,
  output logic            watchdog_reset
);
  import capwd_pkg::*;
  // ****************************************
  // State
  // ****************************************
  logic [7:0] counter_low_byte;
  logic [7:0] counter_high_byte;
  logic [7:0] snapshot;
  logic       counter_run;
  logic [5:0] module_event_flag;
  logic [7:0] counter_mode_reg;
  logic [7:0] module_mode_reg   [MODULES];
  logic [7:0] compare_low_byte  [MODULES];
  logic [7:0] compare_high_byte [MODULES];
  logic [5:0] pin_q;
  logic       tick;
  // ****************************************
  // Decode
  // ****************************************
  wire       watchdog   = counter_mode_reg[MD_WDOG] | counter_mode_reg[MD_LOCK];
  wire       halt_idle  = counter_mode_reg[MD_IDLE] & cpu_idle;
  wire       counting   = (counter_run | watchdog) & ~halt_idle;
  wire       step       = counting & tick;
  wire       low_wrap   = step & (counter_low_byte == 8'hFF);
  wire       full_wrap  = low_wrap & (counter_high_byte == 8'hFF);
  wire       wr_ctl     = reg_write & (reg_addr == ADDR_CONTROL);
  wire       wr_mode    = reg_write & (reg_addr == ADDR_MODE);
  wire       wr_cnt_lo  = reg_write & (reg_addr == ADDR_CNT_LOW) & ~watchdog;
  wire       wr_cnt_hi  = reg_write & (reg_addr == ADDR_CNT_HIGH) & ~watchdog;
  wire [4:0] mod_off    = reg_addr - ADDR_MOD_BASE;
  wire       mod_hit    = (reg_addr >= ADDR_MOD_BASE) && (mod_off < 5'd18);
  wire [2:0] mod_idx    = 3'(mod_off / 5'd3);
  wire [1:0] mod_sel    = 2'(mod_off % 5'd3);
  wire       wd_expire  = watchdog & low_wrap &
                          (compare_high_byte[WDOG_MODULE] == counter_high_byte);
  wire       wd_force   = watchdog & wr_ctl & reg_wdata[WDOG_MODULE];
  wire [7:0] next_lo    = counter_low_byte + 8'h01;
  wire [7:0] next_hi    = counter_high_byte + 8'h01;
  // High byte as it will stand after this step; PWM edges follow the counter's new value
  wire [7:0] hi_after   = low_wrap ? next_hi : counter_high_byte;
  wire [5:0] hit_events;
  // ****************************************
  // Counter and control
  // ****************************************
  // Counter bytes; software writes locked out by the watchdog
  always_ff @(posedge clock) begin
    if (reset) begin
      counter_low_byte <= 8'h00;
      counter_high_byte <= 8'h00;
    end else if (wr_cnt_lo) begin
      counter_low_byte <= reg_wdata;
    end else if (wr_cnt_hi) begin
      counter_high_byte <= reg_wdata;
    end else if (step) begin
      counter_low_byte <= next_lo;
      if (low_wrap) counter_high_byte <= next_hi;
    end
  end
  // Run bit keeps the software value; the watchdog overrides it only in effect
  always_ff @(posedge clock) begin
    if (reset) counter_run <= 1'b0;
    else if (wr_ctl) counter_run <= reg_wdata[CTL_RUN];
  end
  // Mode register: timebase and idle frozen while the watchdog runs
  always_ff @(posedge clock) begin
    if (reset) begin
      counter_mode_reg <= MODE_RESET;
    end else if (wr_mode) begin
      counter_mode_reg[MD_WDOG] <= reg_wdata[MD_WDOG];
      counter_mode_reg[MD_LOCK] <= counter_mode_reg[MD_LOCK] | reg_wdata[MD_LOCK];
      if (!watchdog) begin
        counter_mode_reg[MD_IDLE] <= reg_wdata[MD_IDLE];
        counter_mode_reg[3:1] <= reg_wdata[3:1];
      end
    end
  end
  // Low-byte snapshot of the high byte for coherent reads
  always_ff @(posedge clock) begin
    if (reset) snapshot <= 8'h00;
    else if (reg_read && reg_addr == ADDR_CNT_LOW) snapshot <= counter_high_byte;
  end
  // Flags: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clock) begin
    if (reset) module_event_flag <= 6'h00;
    else if (wr_ctl) module_event_flag <= reg_wdata[5:0] | hit_events;
    else module_event_flag <= module_event_flag | hit_events;
  end
  // Reset pulse; one cycle, the chip reset logic stretches it
  always_ff @(posedge clock) begin
    if (reset) watchdog_reset <= 1'b0;
    else watchdog_reset <= wd_expire | wd_force;
  end
  capwd_timebase u_timebase (
    .clock       (clock),
    .reset       (reset),
    .select      (counter_mode_reg[MD_TB_LSB +: 3]),
    .timer0_tick (timer0_tick),
    .ext_in      (ext_clock_in),
    .xosc_in     (xosc_in),
    .rtc_in      (rtc_in),
    .tick        (tick)
  );
  // ****************************************
  // Compare modules
  // ****************************************
  genvar m;
  generate
    for (m = 0; m < MODULES; m++) begin : g_mod
      logic [7:0] mm;
      logic       wd_mod;
      logic       en;
      logic       freq_mode;
      logic       pwm8;
      logic       pwm16;
      logic       sw_timer;
      logic       hs_out;
      logic       lo_match;
      logic       wd_match;
      logic       hit;
      logic       wr_lo;
      logic       wr_hi;
      logic       wr_mm;
      logic [7:0] half;
      logic [7:0] lo_cmp_next;
      logic       pwm8_set;
      logic       pwm16_set;
      assign wd_mod    = (m == WDOG_MODULE) && watchdog;
      assign mm        = wd_mod ? MM_SWTIMER : module_mode_reg[m];
      assign en        = mm[MM_CMP];
      assign freq_mode = en & mm[MM_TOG] & mm[MM_PWM];
      assign pwm8      = en & ~mm[MM_TOG] & mm[MM_PWM] & ~mm[MM_WIDE];
      assign pwm16     = en & ~mm[MM_TOG] & mm[MM_PWM] & mm[MM_WIDE];
      assign sw_timer  = en & mm[MM_MAT] & ~mm[MM_PWM] & ~wd_mod;
      assign hs_out    = sw_timer & mm[MM_TOG];
      assign lo_match  = step & (counter_low_byte == compare_low_byte[m]);
      assign wd_match  = step & (counter_low_byte == compare_low_byte[m]) &
                         (counter_high_byte == compare_high_byte[m]);
      assign hit       = (pwm16 | sw_timer) ? wd_match : ((freq_mode | pwm8) & lo_match);
      assign hit_events[m] = hit & mm[MM_MAT];
      assign wr_lo     = reg_write & mod_hit & (mod_idx == 3'(m)) & (mod_sel == 2'd1);
      assign wr_hi     = reg_write & mod_hit & (mod_idx == 3'(m)) & (mod_sel == 2'd2);
      assign wr_mm     = reg_write & mod_hit & (mod_idx == 3'(m)) & (mod_sel == 2'd0) & ~wd_mod;
      assign half      = compare_high_byte[m];  // zero wraps to a full 256 step
      // Compare byte in force for the next count; at a wrap it is the reloaded one
      assign lo_cmp_next = low_wrap ? compare_high_byte[m] : compare_low_byte[m];
      // Set while the counter equals the compare value, so a zero gives full duty
      assign pwm8_set  = step & (next_lo == lo_cmp_next);
      assign pwm16_set = step & (next_lo == compare_low_byte[m]) &
                         (hi_after == compare_high_byte[m]);
      // Mode register with comparator enable side effects of byte writes
      always_ff @(posedge clock) begin
        if (reset) module_mode_reg[m] <= 8'h00;
        else if (wr_mm) module_mode_reg[m] <= reg_wdata;
        else if (wr_lo) module_mode_reg[m][MM_CMP] <= 1'b0;
        else if (wr_hi && !wd_mod) module_mode_reg[m][MM_CMP] <= 1'b1;
      end
      // Low byte: software, frequency offset add, PWM reload
      always_ff @(posedge clock) begin
        if (reset) compare_low_byte[m] <= 8'h00;
        else if (wr_lo) compare_low_byte[m] <= reg_wdata;
        else if (freq_mode && lo_match) compare_low_byte[m] <= compare_low_byte[m] + half;
        else if (pwm8 && low_wrap) compare_low_byte[m] <= compare_high_byte[m];
      end
      // High byte; on the watchdog module a write is a kick
      always_ff @(posedge clock) begin
        if (reset) compare_high_byte[m] <= 8'h00;
        else if (wr_hi && wd_mod)
          compare_high_byte[m] <= counter_high_byte + compare_low_byte[m];
        else if (wr_hi) compare_high_byte[m] <= reg_wdata;
      end
      // Output pin; PWM with enable clear stays low
      always_ff @(posedge clock) begin
        if (reset) pin_q[m] <= 1'b1;
        else if (freq_mode && lo_match) pin_q[m] <= ~pin_q[m];
        else if (hs_out && wd_match) pin_q[m] <= ~pin_q[m];
        else if (pwm8 && pwm8_set) pin_q[m] <= 1'b1;
        else if (pwm8 && low_wrap) pin_q[m] <= 1'b0;
        else if (pwm16 && pwm16_set) pin_q[m] <= 1'b1;
        else if (pwm16 && full_wrap) pin_q[m] <= 1'b0;
        else if (!en && mm[MM_PWM]) pin_q[m] <= 1'b0;
        else if (!en) pin_q[m] <= 1'b1;
      end
      assign module_io_pin[m] = pin_q[m];
    end
  endgenerate
  // ****************************************
  // Readback and interrupt
  // ****************************************
  logic [7:0] next_rdata;
  logic [5:0] irq_en;
  always_comb begin
    next_rdata = 8'h00;
    for (int i = 0; i < MODULES; i++) irq_en[i] = module_mode_reg[i][MM_IRQ];
    if (reg_addr == ADDR_CONTROL)
      next_rdata = {1'b0, counter_run, module_event_flag};
    else if (reg_addr == ADDR_MODE) next_rdata = counter_mode_reg;
    else if (reg_addr == ADDR_CNT_LOW) next_rdata = counter_low_byte;
    else if (reg_addr == ADDR_CNT_HIGH) next_rdata = snapshot;
    else if (mod_hit && mod_sel == 2'd0) next_rdata = module_mode_reg[mod_idx];
    else if (mod_hit && mod_sel == 2'd1) next_rdata = compare_low_byte[mod_idx];
    else if (mod_hit) next_rdata = compare_high_byte[mod_idx];
  end
  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      reg_rdata <= 8'h00;
      irq <= 1'b0;
    end else begin
      reg_rdata <= reg_read ? next_rdata : 8'h00;
      irq <= |(module_event_flag & irq_en);
    end
  end
endmodule : capwd_top

// *** test_counter_array_pwm_watchdog.sv ***
module test_counter_array_pwm_watchdog;
  import capwd_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        clear = 1'b1;
  logic [4:0]  reg_addr = 5'h00;
  logic [7:0]  reg_wdata = 8'h00;
  logic [7:0]  reg_rdata, rd_val, lo_a, lo_b;
  logic [5:0]  pins;
  logic [2:0]  sel = 3'h0;
  logic [15:0] edges, highs, e, h;
  logic        wd_rst;
  logic        irq_q;
  logic        wd_seen = 1'b0;
  int          mismatches = 0;
  int          n_compared = 0;
  int          n;
  always #12.5 clock = ~clock;
  // Spare clock sources stay idle; only the system clock timebases are used
  capwd_top dut (.clock, .reset, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
    .timer0_tick(1'b0), .ext_clock_in(1'b0), .xosc_in(1'b0), .rtc_in(1'b0), .cpu_idle(1'b0),
    .module_io_pin(pins), .irq(irq_q), .watchdog_reset(wd_rst));
  // The reset pulse is one cycle wide; latch it so a task returning late still sees it
  always @(posedge clock) wd_seen <= reset ? 1'b0 : (wd_seen | (wd_rst === 1'b1));
  capwd_load load (.clock, .pin(pins[sel]), .clear, .edges, .highs);
  task automatic print_verdict();
    if (mismatches == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // Strobes drop after the taking edge and one idle edge follows, so no double drive
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
    @(posedge clock);
  endtask : rd
  task automatic rc(input string what, input logic [4:0] a, input logic [7:0] x);
    rd(a, rd_val);
    chk(what, 16'(x), 16'(rd_val));
  endtask : rc
  task automatic meas(input logic [2:0] s, input int c);
    sel <= s;
    clear <= 1'b1;
    @(posedge clock);
    clear <= 1'b0;
    repeat (c) @(posedge clock);
    #1 e = edges;
    h = highs;
    @(posedge clock);
  endtask : meas
  // Bounded wait for the reset pulse; running out counts a mismatch
  task automatic wait_wd(input int lim);
    n = 0;
    while (wd_seen !== 1'b1 && n < lim) begin
      @(negedge clock);
      n++;
    end
    if (wd_seen !== 1'b1) mismatches++;
    @(posedge clock);
  endtask : wait_wd
  task automatic do_reset();
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
  endtask : do_reset
  initial begin
    do_reset();
    rc("mode", ADDR_MODE, MODE_RESET);
    rc("offset", 5'h18, 8'h00);
    rd(ADDR_CONTROL, rd_val);
    chk("run", 16'h0, 16'(rd_val[CTL_RUN]));
    rc("unmapped", 5'h1F, 8'h00);
    wr(ADDR_MODE, 8'h28);
    rc("frozen mode", ADDR_MODE, MODE_RESET);
    wr(ADDR_CNT_LOW, 8'h80);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CNT_LOW, lo_a);
    repeat (24) @(posedge clock);
    rd(ADDR_CNT_LOW, lo_b);
    chk("count write", 16'h1, 16'(lo_a < 8'h40));
    chk("forced run", 16'h1, 16'((lo_b - lo_a) inside {8'h02, 8'h03}));
    wr(ADDR_CONTROL, 8'h20);
    wait_wd(4);
    do_reset();
    // Offset two: expiry at the low overflow while the high byte is two
    wr(5'h18, 8'h02);
    wr(5'h19, 8'h55);
    wait_wd(9600);
    chk("expiry", 16'h1, 16'(n > 9000 && n < 9250));
    do_reset();
    wr(ADDR_MODE, 8'h00);
    rc("disabled", ADDR_MODE, 8'h00);
    wr(ADDR_MODE, 8'h08);
    rc("timebase", ADDR_MODE, 8'h08);
    wr(ADDR_CNT_LOW, 8'hF0);
    rc("count load", ADDR_CNT_LOW, 8'hF0);
    wr(5'h09, 8'h80);
    wr(5'h0A, 8'h80);
    wr(5'h08, 8'h42);
    wr(ADDR_CONTROL, 8'h40);
    meas(0, 256);
    meas(0, 256);
    chk("pwm8 half", 16'd128, h);
    wr(5'h0A, 8'hC0);
    meas(0, 256);
    meas(0, 256);
    chk("pwm8 reload", 16'd64, h);
    wr(5'h09, 8'h00);
    meas(0, 256);
    chk("pwm8 off", 16'd0, h);
    wr(ADDR_CONTROL, 8'h00);
    wr(5'h08, 8'hC2);
    wr(5'h09, 8'h00);
    wr(5'h0A, 8'hFF);
    wr(ADDR_CNT_HIGH, 8'hFE);
    wr(ADDR_CNT_LOW, 8'hF0);
    wr(ADDR_CONTROL, 8'h40);
    meas(0, 400);
    chk("pwm16", 16'd256, h);
    wr(5'h0C, 8'h00);
    wr(5'h0D, 8'h10);
    // Frequency mode with match flag and module interrupt enabled
    wr(5'h0B, 8'h4F);
    meas(1, 300);
    meas(1, 320);
    chk("freq 16", 16'd20, e);
    rd(ADDR_CONTROL, rd_val);
    chk("flag 1", 16'h1, 16'(rd_val[1]));
    chk("irq", 16'h1, 16'(irq_q));
    wr(5'h0D, 8'h00);
    meas(1, 300);
    meas(1, 512);
    chk("freq 256", 16'd2, e);
    wr(ADDR_MODE, 8'h40);
    wr(ADDR_MODE, 8'h00);
    rc("lock", ADDR_MODE, 8'h40);
    print_verdict();
  end
endmodule : test_counter_array_pwm_watchdog
